// >>> pkg/hbp_pkg.sv
// shared constants and types for the host bus and interrupt-acknowledge port
package hbp_pkg;

    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;

    // global configuration register: acknowledge delay field
    localparam int ACK_SEL_MSB = 7;
    localparam int ACK_SEL_LSB = 6;

    // acknowledge delay, counted in reference clock edges (both edges count)
    localparam logic [2:0] ACK_EDGES_HALF = 3'h2;
    localparam logic [2:0] ACK_EDGES_ONE = 3'h3;
    localparam logic [2:0] ACK_EDGES_THREE = 3'h6;

    // register addresses touched by the context redirect
    localparam logic [6:0] GLOBAL_FIFO_BYTE_COUNT_ADDR = 7'h3c;
    localparam logic [6:0] RX_BYTE_COUNT_ADDR = 7'h2c;
    localparam logic [6:0] TX_BYTE_COUNT_ADDR = 7'h2d;

    // interrupt type codes held in the context
    localparam logic [2:0] INTR_TYPE_NONE = 3'h0;
    localparam logic [2:0] INTR_TYPE_RX = 3'h1;
    localparam logic [2:0] INTR_TYPE_TX = 3'h2;

    localparam logic [7:0] CTX_RESET = 8'h00;
    localparam logic [7:0] FIXED_VECTOR = 8'h0f;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // current interrupt context, also the arbitration result format
    typedef struct packed {
        logic [2:0] intrType;
        logic chan;
        logic [3:0] fillLevel;
    } hbp_ctx_t;

    // interrupt control bits that shape the vector
    typedef struct packed {
        logic vecFromReg;
        logic modType;
        logic modChan;
    } hbp_intr_ctrl_t;

    // request to the register file behind the port
    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] wdata;
        logic wrStb;
        logic rdStb;
    } hbp_reg_req_t;

    typedef enum {
        ST_IDLE,
        ST_WAIT,
        ST_ACK
    } hbp_ack_state_t;

endpackage

// >>> rtl/hbp_sync.sv
// two-flop synchroniser for a vector of asynchronous pin inputs
module hbp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            meta_r <= INIT;
            syncOut <= INIT;
        end else if (clkEn) begin
            meta_r <= asyncIn;
            syncOut <= meta_r;
        end
    end

endmodule // hbp_sync

// >>> rtl/hbp_host_bus_intack_port.sv
// parallel host bus port with interrupt-acknowledge cycle and context capture
// Function
// - strobe style when select pin high/open; acknowledge pin never driven
// - select pin low gives acknowledge style; writes go with acknowledge assertion
// - strobe style write latched when chip select or write strobe rises first
// - strobe style read drives bus while both low, floats on first rise
// - acknowledge style write is chip select low with read/write low, taken at ack
// - acknowledge style write stored on chip select rise or ack fall, first
// - acknowledge style read driven while selected and read, valid by ack, floats on deselect
// - interrupt acknowledge places plain or context-modified vector on bus
// - interrupt acknowledge in acknowledge style also produces an ack cycle
// - seven-bit address, eight-bit bidirectional data bus
// - ack delay picked by two-bit config field, one to three reference periods
// - shortest ack delay is two reference clock edges
// - deselect before ack abandons ack; access finishes with strobe timing
// - acknowledge pin released after each cycle until the next one
// - interrupt acknowledge or refresh command captures latest arbitration result
// - captured context held until next interrupt acknowledge or refresh
// - vector fixed or from register; optionally embeds type and channel
// - global byte count address redirected by captured context
// - capture with no interrupt asserted loads zero context
// - zero interrupt type means nothing needs service
module hbp_host_bus_intack_port (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic bus_style_select,
    input wire logic chip_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic read_not_write,
    input wire logic intr_ack_n,
    input wire logic ref_clock_in,
    input wire logic [6:0] addrIn,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic dataOe,
    output logic dataAckNOut,
    output logic dataAckNOe,
    input wire logic [7:0] global_chip_config,
    input wire hbp_pkg::hbp_intr_ctrl_t intr_control,
    input wire logic [7:0] intrVectorReg,
    input wire logic arbValid,
    input wire hbp_pkg::hbp_ctx_t arbResult,
    input wire logic refresh_context_cmd,
    output hbp_pkg::hbp_ctx_t current_intr_context,
    output logic serviceNeeded,
    output hbp_pkg::hbp_reg_req_t regReq,
    input wire logic [7:0] regRdData
);

    localparam int CTL_W = 7;
    localparam int BUS_W = hbp_pkg::ADDR_W + hbp_pkg::DATA_W;

    logic [CTL_W-1:0] ctlSync;
    logic [BUS_W-1:0] busSync;
    logic styleSync;
    logic csActS;
    logic rdActS;
    logic wrActS;
    logic rnwS;
    logic iackActS;
    logic refSync;
    logic [6:0] addrS;
    logic [7:0] dataS;

    // all pin inputs, the reference clock among them, cross through two flops
    hbp_sync #(
        .WIDTH(CTL_W),
        .INIT(7'h7f)
    ) u_ctl_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .asyncIn({bus_style_select, chip_select_n, read_strobe_n, write_strobe_n,
                  read_not_write, intr_ack_n, ref_clock_in}),
        .syncOut(ctlSync)
    );

    hbp_sync #(
        .WIDTH(BUS_W),
        .INIT('0)
    ) u_bus_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .asyncIn({addrIn, dataIn}),
        .syncOut(busSync)
    );

    assign styleSync = ctlSync[6];
    assign csActS = !ctlSync[5];
    assign rdActS = !ctlSync[4];
    assign wrActS = !ctlSync[3];
    assign rnwS = ctlSync[2];
    assign iackActS = !ctlSync[1];
    assign refSync = ctlSync[0];
    assign addrS = busSync[14:8];
    assign dataS = busSync[7:0];

    logic ackStyle_r;
    logic csPrev_r;
    logic iackPrev_r;
    logic refPrev_r;
    logic wrCondPrev_r;
    logic rdCondPrev_r;
    logic refEdge;
    logic csRise;
    logic csFall;
    logic iackFall;
    logic wrCond;
    logic rdCond;
    logic [7:0] wrData_r;
    logic [6:0] wrAddr_r;

    assign refEdge = refSync ^ refPrev_r;
    assign csFall = csActS && !csPrev_r;
    assign csRise = !csActS && csPrev_r;
    assign iackFall = iackActS && !iackPrev_r;
    // strobe style conditions; in acknowledge style the read/write line qualifies
    assign wrCond = ackStyle_r ? (csActS && !rnwS) : (csActS && wrActS);
    assign rdCond = ackStyle_r ? (csActS && rnwS) : (csActS && rdActS);

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            csPrev_r <= 1'b0;
            iackPrev_r <= 1'b0;
            // matches the synchroniser's reset level, so no false reference edge follows reset
            refPrev_r <= 1'b1;
            wrCondPrev_r <= 1'b0;
            rdCondPrev_r <= 1'b0;
        end else if (clkEn) begin
            csPrev_r <= csActS;
            iackPrev_r <= iackActS;
            refPrev_r <= refSync;
            wrCondPrev_r <= wrCond;
            rdCondPrev_r <= rdCond;
        end
    end

    // style follows the pin only between accesses, so a cycle never changes style midway
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ackStyle_r <= 1'b0;
        end else if (clkEn && !csActS && !iackActS && !csPrev_r && !iackPrev_r) begin
            ackStyle_r <= !styleSync;
        end
    end

    // write address and data tracked while the write condition holds,
    // so the value from before the terminating edge is the one stored
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wrData_r <= hbp_pkg::DATA_RESET;
            wrAddr_r <= '0;
        end else if (clkEn && wrCond) begin
            wrData_r <= dataS;
            wrAddr_r <= addrS;
        end
    end

    // ---------------- acknowledge cycle ----------------
    hbp_pkg::hbp_ack_state_t ackState_r;
    logic [2:0] edgeCnt_r;
    logic [2:0] edgeTarget;
    logic ackWrPulse;
    logic ackAbandonWr;
    logic cycleActive;

    assign cycleActive = csActS || iackActS;

    always_comb begin
        unique case (global_chip_config[hbp_pkg::ACK_SEL_MSB:hbp_pkg::ACK_SEL_LSB])
            2'h0: edgeTarget = hbp_pkg::ACK_EDGES_HALF;
            2'h1: edgeTarget = hbp_pkg::ACK_EDGES_ONE;
            default: edgeTarget = hbp_pkg::ACK_EDGES_THREE;
        endcase
    end

    // the delay counts reference edges seen after the synchronised start of the
    // cycle; the synchroniser adds up to two system clocks, which stays well
    // below one reference half period at the supported clock ratios
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ackState_r <= hbp_pkg::ST_IDLE;
            edgeCnt_r <= 3'h0;
        end else if (clkEn) begin
            unique case (ackState_r)
                hbp_pkg::ST_IDLE: begin
                    // counter cleared while idle so every cycle starts from zero
                    edgeCnt_r <= 3'h0;
                    if (ackStyle_r && (csFall || iackFall)) begin
                        ackState_r <= hbp_pkg::ST_WAIT;
                    end
                end
                hbp_pkg::ST_WAIT: begin
                    // a deselect before the ack ends the cycle with strobe timing
                    if (!cycleActive) begin
                        ackState_r <= hbp_pkg::ST_IDLE;
                    end else if (refEdge) begin
                        edgeCnt_r <= edgeCnt_r + 3'h1;
                        if (edgeCnt_r + 3'h1 >= edgeTarget) begin
                            ackState_r <= hbp_pkg::ST_ACK;
                        end
                    end
                end
                hbp_pkg::ST_ACK: begin
                    // ack stands until both select and interrupt acknowledge are gone
                    if (!cycleActive) begin
                        ackState_r <= hbp_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // the write is taken at whichever comes first: ack or deselect
    assign ackWrPulse = (ackState_r == hbp_pkg::ST_WAIT) && cycleActive && refEdge &&
                        (edgeCnt_r + 3'h1 >= edgeTarget) && wrCond;

    // deselect first: the data held before the rise is the one stored
    assign ackAbandonWr = (ackState_r == hbp_pkg::ST_WAIT) && csRise && wrCondPrev_r;

    // open drain: only ever pulls low, and only in acknowledge style
    assign dataAckNOut = 1'b0;

    // the enable alone carries the pin; the pull-up gives the released level
    assign dataAckNOe = ackStyle_r && (ackState_r == hbp_pkg::ST_ACK);

    // ---------------- register requests ----------------
    logic strobeWrPulse;
    logic writeNow;
    logic readStart;
    logic [6:0] rdAddr;
    logic [6:0] effAddr;

    // strobe style: write ends at the first rise of select or write strobe
    assign strobeWrPulse = !ackStyle_r && wrCondPrev_r && !wrCond;
    assign writeNow = strobeWrPulse || ackWrPulse || ackAbandonWr;
    // one request per read condition; the vector read needs none
    assign readStart = rdCond && !rdCondPrev_r && !iackActS;
    assign rdAddr = writeNow ? wrAddr_r : addrS;

    // the global byte count address points at whichever fifo the context names
    always_comb begin
        effAddr = rdAddr;
        if (rdAddr == hbp_pkg::GLOBAL_FIFO_BYTE_COUNT_ADDR) begin
            if (current_intr_context.intrType == hbp_pkg::INTR_TYPE_RX) begin
                effAddr = hbp_pkg::RX_BYTE_COUNT_ADDR;
            end else if (current_intr_context.intrType == hbp_pkg::INTR_TYPE_TX) begin
                effAddr = hbp_pkg::TX_BYTE_COUNT_ADDR;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            regReq <= '0;
        end else if (clkEn) begin
            regReq.addr <= effAddr;
            regReq.wdata <= ackWrPulse ? dataS : wrData_r;
            regReq.wrStb <= writeNow;
            regReq.rdStb <= readStart && !writeNow;
        end
    end

    // ---------------- interrupt context ----------------
    logic capture;

    // capture on the synchronised fall only, so a long acknowledge captures once
    assign capture = iackFall || refresh_context_cmd;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            current_intr_context <= hbp_pkg::CTX_RESET;
        end else if (clkEn && capture) begin
            if (arbValid) begin
                current_intr_context <= arbResult;
            end else begin
                current_intr_context <= hbp_pkg::CTX_RESET;
            end
        end
    end

    // derived from the held context, so it changes only at a capture
    assign serviceNeeded = current_intr_context.intrType != hbp_pkg::INTR_TYPE_NONE;

    logic [7:0] vector;

    // type lands in bits 3:1 and channel in bit 0 when modification is on
    always_comb begin
        vector = intr_control.vecFromReg ? intrVectorReg : hbp_pkg::FIXED_VECTOR;
        if (intr_control.modType) begin
            vector[3:1] = current_intr_context.intrType;
        end
        if (intr_control.modChan) begin
            vector[0] = current_intr_context.chan;
        end
    end

    // ---------------- read data ----------------
    logic rdPending_r;
    logic vecPending_r;

    // register file answers one cycle after the read strobe;
    // the vector waits one cycle so it sees the freshly captured context
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rdPending_r <= 1'b0;
            vecPending_r <= 1'b0;
        end else if (clkEn) begin
            rdPending_r <= regReq.rdStb;
            vecPending_r <= iackFall;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            dataOut <= hbp_pkg::DATA_RESET;
        end else if (clkEn) begin
            if (vecPending_r) begin
                dataOut <= vector;
            end else if (rdPending_r) begin
                dataOut <= regRdData;
            end
        end
    end

    // register data ready three cycles after the read begins, the vector two; well before the earliest ack
    assign dataOe = iackActS || rdCond;

endmodule // hbp_host_bus_intack_port

// >>> tb/hbp_host_bus_intack_port_props.sv
// assertion checker for the host bus and interrupt-acknowledge port
module hbp_host_bus_intack_port_props (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic bus_style_select,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic intr_ack_n,
    input wire hbp_pkg::hbp_intr_ctrl_t intr_control,
    input wire logic [7:0] dataOut,
    input wire logic dataOe,
    input wire logic dataAckNOe,
    input wire logic arbValid,
    input wire hbp_pkg::hbp_ctx_t arbResult,
    input wire logic refresh_context_cmd,
    input wire hbp_pkg::hbp_ctx_t current_intr_context,
    input wire hbp_pkg::hbp_reg_req_t regReq
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    AST_NO_ACK_STROBE: assert property (
        dataAckNOe |-> !$past(bus_style_select, 3)) else $error("ack in strobe style");
    AST_WRITE_LATCH: assert property (
        $rose(write_strobe_n) && !chip_select_n && bus_style_select |-> ##[2:5] regReq.wrStb)
        else $error("strobe write not taken");
    AST_BUS_FLOAT: assert property (
        chip_select_n && $past(chip_select_n, 3) && intr_ack_n && $past(intr_ack_n, 3)
        |-> !dataOe) else $error("bus driven while idle");
    AST_IACK_ACK: assert property (
        $fell(intr_ack_n) && chip_select_n && !bus_style_select |-> ##[4:40] dataAckNOe)
        else $error("no ack for interrupt acknowledge");
    AST_ACK_MIN: assert property (
        $rose(dataAckNOe) |-> !$past(chip_select_n, 5) || !$past(intr_ack_n, 5))
        else $error("ack too early");
    AST_ACK_RELEASE: assert property (
        $rose(chip_select_n & intr_ack_n) |-> ##4 !dataAckNOe [*3])
        else $error("ack not released");
    AST_CTX_LOAD: assert property (
        refresh_context_cmd && arbValid |=> current_intr_context == $past(arbResult))
        else $error("context not captured");
    AST_CTX_HOLD: assert property (
        !$stable(current_intr_context)
        |-> $past(refresh_context_cmd) || !$past(intr_ack_n, 2) || !$past(rst_b))
        else $error("context changed without capture");
    AST_CTX_ZERO: assert property (
        refresh_context_cmd && !arbValid |=> current_intr_context == hbp_pkg::CTX_RESET)
        else $error("idle capture not zero");
    AST_FIXED_VEC: assert property (
        $fell(intr_ack_n) && intr_control == 3'h0 |-> ##5 dataOut == hbp_pkg::FIXED_VECTOR)
        else $error("wrong fixed vector");
endmodule // hbp_host_bus_intack_port_props

bind hbp_host_bus_intack_port hbp_host_bus_intack_port_props u_props (
    .sys_clk(sys_clk), .rst_b(rst_b), .bus_style_select(bus_style_select),
    .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n), .intr_ack_n(intr_ack_n),
    .intr_control(intr_control), .dataOut(dataOut), .dataOe(dataOe),
    .dataAckNOe(dataAckNOe), .arbValid(arbValid), .arbResult(arbResult),
    .refresh_context_cmd(refresh_context_cmd), .current_intr_context(current_intr_context),
    .regReq(regReq));

// >>> tb/hbp_host_model.sv
// host processor model driving the parallel bus pins
module hbp_host_model (
    input wire logic clk,
    output logic chip_select_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic read_not_write,
    output logic intr_ack_n,
    output logic [6:0] addr,
    output logic [7:0] busIn,
    input wire logic [7:0] dataOut,
    input wire logic dataOe,
    input wire logic dataAckNOe,
    input wire logic dataAckNOut
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] hostD = 8'h00;
    logic [7:0] lastBus = 8'h00;
    logic hostOe = 1'h0;
    logic csFirst = 1'h0;
    logic ackN;
    int ackCnt = 0;
    initial {chip_select_n, read_strobe_n, write_strobe_n, read_not_write, intr_ack_n} = 5'h1f;
    initial addr = 7'h00;
    // pull-up on the ack pin; a released data bus toggles so stale values never match
    assign ackN = dataAckNOe ? dataAckNOut : 1'h1;
    assign busIn = dataOe ? dataOut : hostOe ? hostD : ~lastBus;
    always @(posedge clk) begin
        lastBus <= busIn;
        if (ackN === 1'h0) ackCnt <= ackCnt + 1;
    end
    // kind 0 strobe style, 1 acknowledge style, 2 interrupt acknowledge
    task automatic access(input int kind, input logic w, input logic [6:0] a,
        input logic [7:0] d, input int hold, output logic [7:0] rd, output int cyc);
        @(posedge clk);
        #1;
        addr = a;
        read_not_write = !w;
        hostOe = w;
        hostD = d;
        if (kind == 2) intr_ack_n = 1'h0;
        else chip_select_n = 1'h0;
        if (kind == 0) {read_strobe_n, write_strobe_n} = w ? 2'h2 : 2'h1;
        for (cyc = 1; cyc < 80; cyc++) begin
            @(posedge clk);
            if (hold > 0 ? cyc >= hold : ackN === 1'h0) break;
        end
        rd = busIn;
        #1;
        if (csFirst) chip_select_n = 1'h1;
        else {read_strobe_n, write_strobe_n} = 2'h3;
        @(posedge clk);
        #1;
        {chip_select_n, read_strobe_n, write_strobe_n, intr_ack_n} = 4'hf;
        hostOe = 1'h0;
        repeat (5) @(posedge clk);
    endtask
endmodule // hbp_host_model

// >>> tb/hbp_host_bus_intack_port_test.sv
// self-checking bench for the host bus and interrupt-acknowledge port
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("unexpected %s: expected %h, seen %h", n, e, g); end end
module hbp_host_bus_intack_port_test;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {logic s; logic w; logic [6:0] a; logic [7:0] d;} hbp_row_t;
    hbp_row_t rows [6] = '{'{1'h1, 1'h1, 7'h10, 8'h55}, '{1'h1, 1'h1, 7'h7f, 8'ha3},
        '{1'h1, 1'h0, 7'h00, 8'h00}, '{1'h1, 1'h0, 7'h7f, 8'h00},
        '{1'h0, 1'h1, 7'h22, 8'hc4}, '{1'h0, 1'h0, 7'h41, 8'h00}};
    logic sys_clk = 1'h0, rst_b = 1'h0, bus_style_select = 1'h1, ref_clock_in = 1'h0;
    logic arbValid = 1'h0, refresh_context_cmd = 1'h0;
    logic [7:0] global_chip_config = 8'h00, intrVectorReg = 8'ha0, regRdData = 8'h00, rd;
    hbp_pkg::hbp_intr_ctrl_t intr_control = 3'h0;
    hbp_pkg::hbp_ctx_t arbResult = 8'h00;
    wire logic chip_select_n, read_strobe_n, write_strobe_n, read_not_write, intr_ack_n;
    wire logic [6:0] addrIn;
    wire logic [7:0] dataIn;
    logic [7:0] dataOut;
    logic dataOe, dataAckNOut, dataAckNOe, serviceNeeded;
    hbp_pkg::hbp_ctx_t current_intr_context;
    hbp_pkg::hbp_reg_req_t regReq, lastWr;
    int errors = 0, checked = 0, cyc, lo, acks;
    always #4 sys_clk = ~sys_clk;
    // 21 ns half period: every eighth reference edge falls on a system clock rising edge
    always #21 ref_clock_in = ~ref_clock_in;
    // register file stand-in: read data echoes the requested address
    always @(posedge sys_clk) begin
        regRdData <= {1'h1, regReq.addr};
        if (regReq.wrStb) lastWr <= regReq;
    end
    hbp_host_bus_intack_port DUT (.sys_clk(sys_clk), .rst_b(rst_b), .clkEn(1'h1),
        .bus_style_select(bus_style_select), .chip_select_n(chip_select_n),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .read_not_write(read_not_write), .intr_ack_n(intr_ack_n), .ref_clock_in(ref_clock_in),
        .addrIn(addrIn), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
        .dataAckNOut(dataAckNOut), .dataAckNOe(dataAckNOe),
        .global_chip_config(global_chip_config), .intr_control(intr_control),
        .intrVectorReg(intrVectorReg), .arbValid(arbValid), .arbResult(arbResult),
        .refresh_context_cmd(refresh_context_cmd), .current_intr_context(current_intr_context),
        .serviceNeeded(serviceNeeded), .regReq(regReq), .regRdData(regRdData));
    hbp_host_model HOST (.clk(sys_clk), .chip_select_n(chip_select_n),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .read_not_write(read_not_write), .intr_ack_n(intr_ack_n), .addr(addrIn),
        .busIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .dataAckNOe(dataAckNOe),
        .dataAckNOut(dataAckNOut));
    task automatic style(input logic s);
        @(posedge sys_clk);
        #1;
        bus_style_select = s;
        repeat (6) @(posedge sys_clk);
    endtask
    task automatic refresh(input logic v, input hbp_pkg::hbp_ctx_t r);
        @(posedge sys_clk);
        #1;
        arbValid = v;
        arbResult = r;
        refresh_context_cmd = 1'h1;
        @(posedge sys_clk);
        #1;
        refresh_context_cmd = 1'h0;
        @(posedge sys_clk);
        #1;
    endtask
    function automatic logic [7:0] vec(hbp_pkg::hbp_intr_ctrl_t c, hbp_pkg::hbp_ctx_t x);
        vec = c.vecFromReg ? intrVectorReg : hbp_pkg::FIXED_VECTOR;
        if (c.modType) vec[3:1] = x.intrType;
        if (c.modChan) vec[0] = x.chan;
    endfunction
    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        #1;
        rst_b = 1'h1;
        @(posedge sys_clk);
        #1;
        `CHK("ack enable", 1'h0, dataAckNOe)
        `CHK("context", hbp_pkg::CTX_RESET, current_intr_context)
        `CHK("bus drive", 1'h0, dataOe)
        $display("reset done");
        foreach (rows[i]) begin
            if (rows[i].s !== bus_style_select) style(rows[i].s);
            HOST.access(!rows[i].s, rows[i].w, rows[i].a, rows[i].d, rows[i].s ? 8 : 0, rd, cyc);
            if (rows[i].w) begin
                `CHK("write addr", rows[i].a, lastWr.addr)
                `CHK("write data", rows[i].d, lastWr.wdata)
            end else `CHK("read data", {1'h1, rows[i].a}, rd)
        end
        $display("table done");
        style(1'h1);
        HOST.csFirst = 1'h1;
        HOST.access(0, 1'h1, 7'h33, 8'h96, 8, rd, cyc);
        HOST.csFirst = 1'h0;
        `CHK("select first write", 8'h96, lastWr.wdata)
        $display("select release done");
        style(1'h0);
        for (int c = 0; c < 4; c++) begin
            global_chip_config = {c[1:0], 6'h00};
            HOST.access(1, 1'h0, 7'h05, 8'h00, 0, rd, cyc);
            lo = c == 0 ? 2 : c == 1 ? 3 : 6;
            `CHK("ack delay", 1'h1, cyc >= 2 * lo + 2 && cyc <= 3 * lo + 8)
            `CHK("ack read", 8'h85, rd)
        end
        acks = HOST.ackCnt;
        HOST.access(1, 1'h1, 7'h0a, 8'h5c, 4, rd, cyc);
        `CHK("abort write", 8'h5c, lastWr.wdata)
        `CHK("abort ack", acks, HOST.ackCnt)
        $display("ack delay done");
        style(1'h1);
        refresh(1'h1, {hbp_pkg::INTR_TYPE_RX, 1'h0, 4'h5});
        `CHK("context", 8'h25, current_intr_context)
        `CHK("service", 1'h1, serviceNeeded)
        arbResult = 8'h47;
        HOST.access(0, 1'h0, hbp_pkg::GLOBAL_FIFO_BYTE_COUNT_ADDR, 8'h00, 8, rd, cyc);
        `CHK("held context", 8'h25, current_intr_context)
        `CHK("rx count", {1'h1, hbp_pkg::RX_BYTE_COUNT_ADDR}, rd)
        refresh(1'h1, {hbp_pkg::INTR_TYPE_TX, 1'h1, 4'h3});
        HOST.access(0, 1'h0, hbp_pkg::GLOBAL_FIFO_BYTE_COUNT_ADDR, 8'h00, 8, rd, cyc);
        `CHK("tx count", {1'h1, hbp_pkg::TX_BYTE_COUNT_ADDR}, rd)
        for (int k = 0; k < 3; k++) begin
            intr_control = k == 0 ? 3'h3 : k == 1 ? 3'h4 : 3'h0;
            HOST.access(2, 1'h0, 7'h00, 8'h00, 8, rd, cyc);
            `CHK("vector", vec(intr_control, 8'h53), rd)
        end
        style(1'h0);
        refresh(1'h0, 8'h53);
        `CHK("zero context", hbp_pkg::CTX_RESET, current_intr_context)
        `CHK("no service", 1'h0, serviceNeeded)
        intr_control = 3'h3;
        acks = HOST.ackCnt;
        HOST.access(2, 1'h0, 7'h00, 8'h00, 0, rd, cyc);
        `CHK("iack ack", 1'h1, HOST.ackCnt > acks)
        `CHK("zero vector", 8'h00, rd)
        $display("context and vector done");
        complete_run;
    end
    // the sequence needs about 400 cycles; allow ample margin
    initial begin
        #40000;
        errors++;
        complete_run;
    end
endmodule // hbp_host_bus_intack_port_test
